// ==== hw/lvs_map.svh ====
// Constants of the 7:1 serializer: slots, lanes, widths and patterns.
`ifndef LVS_MAP_SVH
`define LVS_MAP_SVH

`define LVS_SLOTS      7           // Bit slots per lane per word
`define LVS_LANES      4           // Serial data lanes
`define LVS_WIDTH      28          // Parallel word width
`define LVS_DEPTH      8           // Words buffered between domains
`define LVS_LAST_SLOT  3'h6        // Slot index at which a word is loaded
`define LVS_FIRST_SLOT 3'h0        // Slot index that starts a word
`define LVS_CLK_PAT    7'h63       // Clock level per slot, slot 0 in bit 0
`define LVS_SEL_RISE   1'h1        // Select level that picks rising edge
`define LVS_SLOT_RST   3'h0        // Slot counter reset value
`define LVS_WORD_RST   28'h0000000 // Word sent before any data arrives

`endif

// ==== hw/lvs_pkg.sv ====
// Types shared by the serializer files.
package lvs_pkg;
`include "lvs_map.svh"
   // Parallel word as strobed in
   typedef logic [`LVS_WIDTH-1:0] lvs_word_t;
   // Link side state, one-hot
   typedef enum logic [1:0] {
      LVS_LK_IDLE = 2'b01,  // No word queued, lanes send zeros
      LVS_LK_RUN  = 2'b10   // Words are flowing
   } lvs_link_st_t;
endpackage

// ==== hw/lvs_fifo.sv ====
// Dual-clock FIFO carrying strobed words to the link clock domain.
`timescale 1ns/1ns
module lvs_fifo #(
   parameter int W = 28,                // Word width
   parameter int D = 8                  // Depth, power of two, at least 4
) (
   input  wire logic         wr_clk,    // Capture side clock
   input  wire logic         wr_rstn,   // Capture side reset, active low
   input  wire logic         wr_valid,  // Word offered
   input  wire logic [W-1:0] wr_data,   // Word offered
   output      logic         wr_ready,  // Room for a word
   input  wire logic         rd_clk,    // Link side clock
   input  wire logic         rd_rstn,   // Link side reset, active low
   output      logic         rd_valid,  // Word waiting
   output      logic [W-1:0] rd_data,   // Oldest word, shown ahead
   input  wire logic         rd_ready   // Pop oldest word
);
   localparam int AW = $clog2(D);

   logic [W-1:0] mem [D];               // Word storage
   logic [AW:0]  wbin_q, wgray_q;       // Write pointer, binary and gray
   logic [AW:0]  rbin_q, rgray_q;       // Read pointer, binary and gray
   logic [AW:0]  rg_s1_q, rg_s2_q;      // Read gray in write domain
   logic [AW:0]  wg_s1_q, wg_s2_q;      // Write gray in read domain
   logic [AW:0]  wbin_d, rbin_d;        // Next pointers
   logic         push, pop;             // Accepted transfers

   // Full compares against the read pointer with its top two bits flipped
   assign wr_ready = wgray_q !=
                     {~rg_s2_q[AW:AW-1], rg_s2_q[AW-2:0]};
   assign rd_valid = rgray_q != wg_s2_q;
   assign rd_data  = mem[rbin_q[AW-1:0]];
   assign push     = wr_valid && wr_ready;
   assign pop      = rd_valid && rd_ready;
   assign wbin_d   = wbin_q + (AW+1)'(1);
   assign rbin_d   = rbin_q + (AW+1)'(1);

   // Storage holds no reset, only the pointers decide what is valid
   always_ff @(posedge wr_clk) begin
      if (push) begin
         mem[wbin_q[AW-1:0]] <= wr_data;
      end
   end

   // Write pointer; gray copy changes one bit per push for the crossing
   always_ff @(posedge wr_clk or negedge wr_rstn) begin
      if (!wr_rstn) begin
         wbin_q  <= '0;
         wgray_q <= '0;
      end else if (push) begin
         wbin_q  <= wbin_d;
         wgray_q <= wbin_d ^ (wbin_d >> 1);
      end
   end

   // Read pointer
   always_ff @(posedge rd_clk or negedge rd_rstn) begin
      if (!rd_rstn) begin
         rbin_q  <= '0;
         rgray_q <= '0;
      end else if (pop) begin
         rbin_q  <= rbin_d;
         rgray_q <= rbin_d ^ (rbin_d >> 1);
      end
   end

   // Read pointer into write domain, two flops
   always_ff @(posedge wr_clk or negedge wr_rstn) begin
      if (!wr_rstn) begin
         rg_s1_q <= '0;
         rg_s2_q <= '0;
      end else begin
         rg_s1_q <= rgray_q;
         rg_s2_q <= rg_s1_q;
      end
   end

   // Write pointer into read domain, two flops
   always_ff @(posedge rd_clk or negedge rd_rstn) begin
      if (!rd_rstn) begin
         wg_s1_q <= '0;
         wg_s2_q <= '0;
      end else begin
         wg_s1_q <= wgray_q;
         wg_s2_q <= wg_s1_q;
      end
   end

   // A refused word leaves the write pointer where it was
   property p_no_overrun;
      @(posedge wr_clk) disable iff (!wr_rstn)
      (wr_valid && !wr_ready) |=> wbin_q == $past(wbin_q);
   endproperty
   a_no_overrun: assert property (p_no_overrun)
      else $error("write pointer moved while full");
endmodule

// ==== hw/lvs_serializer.sv ====
// Top of the 7:1 serializer: strobe capture, buffer and lane shifter.
`timescale 1ns/1ns
module lvs_serializer
   import lvs_pkg::*;
(
   input  wire logic               clock,            // System clock
   input  wire logic               rstn,             // Async reset, low
   input  wire logic               link_clock,       // Bit slot clock
   input  wire logic               strobe_clock_input, // Strobe pin
   input  wire logic               strobe_edge_select, // High: rising
   input  wire lvs_pkg::lvs_word_t parallel_data_inputs, // Data pins
   output      logic [3:0]         serial_lanes_p,   // Lanes, true side
   output      logic [3:0]         serial_lanes_n,   // Lanes, inverted
   output      logic               forwarded_link_clock_p, // Clock, true
   output      logic               forwarded_link_clock_n, // Clock, inv
   output      logic               capture_overrun   // Word lost, pulse
);
   import lvs_pkg::*;

   // ---------------- System clock domain ----------------
   logic      stb_s1_q, stb_s2_q, stb_s3_q; // Strobe sync and history
   logic      sel_s1_q, sel_s2_q;           // Edge select sync
   lvs_word_t dat_s1_q, dat_s2_q;           // Data sync
   logic      stb_rise, stb_fall;           // Strobe edges seen
   logic      strobe_hit;                   // Chosen edge seen
   logic      cap_valid_q;                  // Captured word waiting
   lvs_word_t cap_data_q;                   // Captured word
   logic      wr_ready;                     // Buffer has room
   logic      cap_take;                     // Capture may load
   logic      overrun_q;                    // Word dropped the cycle before

   // Pins cross into the clock domain through two flops
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         stb_s1_q <= 1'h0;
         stb_s2_q <= 1'h0;
         stb_s3_q <= 1'h0;
         sel_s1_q <= 1'h0;
         sel_s2_q <= 1'h0;
         dat_s1_q <= `LVS_WORD_RST;
         dat_s2_q <= `LVS_WORD_RST;
      end else begin
         stb_s1_q <= strobe_clock_input;
         stb_s2_q <= stb_s1_q;
         stb_s3_q <= stb_s2_q;          // History for edge detect
         sel_s1_q <= strobe_edge_select;
         sel_s2_q <= sel_s1_q;
         dat_s1_q <= parallel_data_inputs;
         dat_s2_q <= dat_s1_q;          // Same latency as the strobe
      end
   end

   // Edges are judged on the second and third flops, never the first
   assign stb_rise   = stb_s2_q && !stb_s3_q;
   assign stb_fall   = !stb_s2_q && stb_s3_q;
   // Open or low select falls back to the falling edge
   assign strobe_hit = (sel_s2_q == `LVS_SEL_RISE) ? stb_rise
                                                   : stb_fall;
   assign cap_take   = !cap_valid_q || wr_ready;

   // Capture register; a full buffer stalls it and a new edge is lost
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         cap_valid_q <= 1'h0;
         cap_data_q  <= `LVS_WORD_RST;
      end else if (strobe_hit && cap_take) begin
         cap_valid_q <= 1'h1;
         cap_data_q  <= dat_s2_q;
      end else if (wr_ready) begin
         cap_valid_q <= 1'h0;           // Word handed to the buffer
      end
   end

   // Overrun pulse when an edge arrives with nowhere to put the word
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         overrun_q <= 1'h0;
      end else begin
         overrun_q <= strobe_hit && !cap_take;
      end
   end
   assign capture_overrun = overrun_q;

   // ---------------- Buffer between domains ----------------
   logic      rd_valid;                 // Word waiting at link side
   lvs_word_t rd_data;                  // Oldest word
   logic      rd_ready;                 // Pop at word boundary

   lvs_fifo #(
      .W (`LVS_WIDTH),
      .D (`LVS_DEPTH)
   ) u_fifo (
      .wr_clk   (clock),
      .wr_rstn  (rstn),
      .wr_valid (cap_valid_q),
      .wr_data  (cap_data_q),
      .wr_ready (wr_ready),
      .rd_clk   (link_clock),
      .rd_rstn  (rstn),
      .rd_valid (rd_valid),
      .rd_data  (rd_data),
      .rd_ready (rd_ready)
   );

   // ---------------- Link clock domain ----------------
   logic [2:0]   slot_q;                // Current bit slot
   lvs_link_st_t lk_st_q;               // Link state
   lvs_word_t    word_q;                // Word being shifted out
   logic         fwd_q, fwd_n_q;        // Forwarded clock pair
   logic [3:0]   lane_p_q, lane_n_q;    // Lane output flops
   logic         at_last;               // Word boundary
   // Clock level per slot, slot 0 in bit 0
   localparam logic [6:0] CLK_PAT = `LVS_CLK_PAT;

   assign at_last  = slot_q == `LVS_LAST_SLOT;
   assign rd_ready = at_last;           // One pop per seven slots

   // Slot counter runs free so the forwarded clock never stops
   always_ff @(posedge link_clock or negedge rstn) begin
      if (!rstn) begin
         slot_q <= `LVS_SLOT_RST;
      end else if (at_last) begin
         slot_q <= `LVS_FIRST_SLOT;
      end else begin
         slot_q <= slot_q + 3'h1;
      end
   end

   // Load next word at the boundary; an empty buffer sends zeros
   always_ff @(posedge link_clock or negedge rstn) begin
      if (!rstn) begin
         word_q  <= `LVS_WORD_RST;
         lk_st_q <= LVS_LK_IDLE;
      end else if (at_last) begin
         word_q  <= rd_valid ? rd_data : `LVS_WORD_RST;
         case (lk_st_q)
            LVS_LK_IDLE: begin
               lk_st_q <= rd_valid ? LVS_LK_RUN : LVS_LK_IDLE;
            end
            LVS_LK_RUN: begin
               lk_st_q <= rd_valid ? LVS_LK_RUN : LVS_LK_IDLE;
            end
            default: begin
               lk_st_q <= LVS_LK_IDLE;
            end
         endcase
      end
   end

   // Forwarded clock from the slot pattern, in step with the lanes
   always_ff @(posedge link_clock or negedge rstn) begin
      if (!rstn) begin
         fwd_q   <= 1'h0;
         fwd_n_q <= 1'h1;
      end else begin
         // One pattern bit per slot; both halves come from the same bit
         fwd_q   <= CLK_PAT[slot_q];
         fwd_n_q <= !CLK_PAT[slot_q];
      end
   end
   assign forwarded_link_clock_p = fwd_q;
   assign forwarded_link_clock_n = fwd_n_q;

   // Lane l carries word bit l*7+slot in that slot
   for (genvar l = 0; l < `LVS_LANES; l++) begin : g_lane
      always_ff @(posedge link_clock or negedge rstn) begin
         if (!rstn) begin
            lane_p_q[l] <= 1'h0;
            lane_n_q[l] <= 1'h1;
         end else begin
            lane_p_q[l] <= word_q[l*`LVS_SLOTS + slot_q];
            lane_n_q[l] <= !word_q[l*`LVS_SLOTS + slot_q];
         end
      end
   end
   assign serial_lanes_p = lane_p_q;
   assign serial_lanes_n = lane_n_q;

   // ---------------- Checks ----------------
   sequence s_hi2;  fwd_q [*2]; endsequence
   sequence s_lo3;  !fwd_q [*3]; endsequence

   property p_slot_wrap;
      @(posedge link_clock) disable iff (!rstn)
      at_last |=> slot_q == 3'h0 ##6 at_last;
   endproperty
   a_slot_wrap: assert property (p_slot_wrap)
      else $error("word is not seven slots long");

   property p_clk_shape;
      @(posedge link_clock) disable iff (!rstn)
      slot_q == 3'h0 |=> s_hi2 ##1 s_lo3 ##1 s_hi2;
   endproperty
   a_clk_shape: assert property (p_clk_shape)
      else $error("forwarded clock shape wrong");

   property p_clk_pair;
      @(posedge link_clock) disable iff (!rstn)
      fwd_q != fwd_n_q;
   endproperty
   a_clk_pair: assert property (p_clk_pair)
      else $error("forwarded clock pair not complementary");

   property p_lane_map;
      @(posedge link_clock) disable iff (!rstn)
      (at_last && rd_valid) |=> word_q == $past(rd_data)
         ##1 lane_p_q[0] == word_q[0] && lane_p_q[3] == word_q[21];
   endproperty
   a_lane_map: assert property (p_lane_map)
      else $error("slot 0 bits not on lanes");

   property p_rise_cap;
      @(posedge clock) disable iff (!rstn)
      (sel_s2_q && stb_rise && cap_take) |=>
         cap_valid_q && cap_data_q == $past(dat_s2_q);
   endproperty
   a_rise_cap: assert property (p_rise_cap)
      else $error("rising edge did not capture");

   property p_fall_cap;
      @(posedge clock) disable iff (!rstn)
      (!sel_s2_q && stb_fall && cap_take) |=>
         cap_valid_q && cap_data_q == $past(dat_s2_q);
   endproperty
   a_fall_cap: assert property (p_fall_cap)
      else $error("falling edge did not capture");

   property p_wrong_edge;
      @(posedge clock) disable iff (!rstn)
      (!cap_valid_q && (sel_s2_q ? stb_fall : stb_rise)) |=> !cap_valid_q;
   endproperty
   a_wrong_edge: assert property (p_wrong_edge)
      else $error("captured on unselected edge");

   property p_idle_zero;
      @(posedge link_clock) disable iff (!rstn)
      (at_last && !rd_valid) |=> word_q == `LVS_WORD_RST
         && lk_st_q == LVS_LK_IDLE;
   endproperty
   a_idle_zero: assert property (p_idle_zero)
      else $error("empty buffer did not send zeros");
endmodule

// ==== test/lvs_deser.sv ====
// Far-end deserializer model: rebuilds 28-bit words from the four lanes.
`timescale 1ns/1ns
module lvs_deser
   import lvs_pkg::*;
(
   input  wire logic               link_clock, // Bit slot clock
   input  wire logic               rstn,       // Reset, active low
   input  wire logic [3:0]         lanes_p,    // Lanes, true side
   input  wire logic [3:0]         lanes_n,    // Lanes, inverted side
   input  wire logic               fwd_p,      // Forwarded clock, true
   input  wire logic               fwd_n,      // Forwarded clock, inv
   output      lvs_pkg::lvs_word_t word,       // Last word rebuilt
   output      int                 word_cnt,   // Bumps once per word
   output      int                 bad_cnt     // Framing faults seen
);
   localparam logic [6:0] PAT = 7'h63;         // Clock level per slot
   lvs_word_t  acc;                            // Word being assembled
   logic       synced;                         // Word boundary found
   int         lows;                           // Low clock samples in a row
   int         slot;                           // Slot just sampled
   int         nxt;                            // Slot being sampled
   // Sample mid-slot, away from the edge where the outputs move
   always @(negedge link_clock or negedge rstn) begin
      if (!rstn) begin
         synced = 1'b0;
         lows = 0;
         slot = 0;
         acc = '0;
         word = '0;
         word_cnt = 0;
         bad_cnt = 0;
      end else begin
         // Both halves of every pair must stay complementary
         if (lanes_n !== ~lanes_p || fwd_n !== ~fwd_p) bad_cnt++;
         nxt = (slot == 6) ? 0 : slot + 1;
         // A rise after three low slots marks slot 5; the short low
         // parked during reset cannot fake it
         if (lows >= 3 && fwd_p === 1'b1) begin
            if (synced && nxt != 5) bad_cnt++;
            nxt = 5;
            synced = 1'b1;
         end else if (synced && fwd_p !== PAT[nxt]) begin
            bad_cnt++;
         end
         // Same bit placement as the sender: bit lane*7+slot
         for (int l = 0; l < 4; l++) acc[l*7+nxt] = lanes_p[l];
         slot = nxt;
         lows = (fwd_p === 1'b0) ? lows + 1 : 0;
         if (synced && nxt == 6) begin
            word = acc;
            word_cnt++;
         end
      end
   end
endmodule

// ==== test/tb_lvs_serializer.sv ====
// Bench for the 7:1 serializer against a queue model of strobed words.
`timescale 1ns/1ns
module tb_lvs_serializer;
   import lvs_pkg::*;
   logic       clock;      // System clock
   logic       rstn;       // Reset, active low
   logic       link_clock; // Bit slot clock
   logic       strobe;     // Strobe pin
   logic       sel;        // Edge select pin
   lvs_word_t  din;        // Data pins
   logic [3:0] lanes_p;    // Lanes, true
   logic [3:0] lanes_n;    // Lanes, inverted
   logic       fwd_p;      // Forwarded clock, true
   logic       fwd_n;      // Forwarded clock, inverted
   logic       ovr;        // Lost word pulse
   lvs_word_t  rx_word;    // Word from the far end
   int         rx_cnt;     // Far end word counter
   int         rx_bad;     // Far end framing faults
   lvs_word_t  exp_q[$];   // Words strobed, oldest first
   int         error_cnt;  // Mismatches
   int         n_tests;    // Comparisons
   int         cycles;     // Clock cycles run
   int         ovr_cnt;    // Overrun pulses seen
   int         got_cnt;    // Data words received
   int         base;       // Words received before the burst
   logic       lossy;      // Drops are allowed now
   lvs_serializer u_lvs_serializer (
      .clock(clock), .rstn(rstn), .link_clock(link_clock),
      .strobe_clock_input(strobe), .strobe_edge_select(sel),
      .parallel_data_inputs(din), .serial_lanes_p(lanes_p),
      .serial_lanes_n(lanes_n), .forwarded_link_clock_p(fwd_p),
      .forwarded_link_clock_n(fwd_n), .capture_overrun(ovr));
   lvs_deser u_lvs_deser (
      .link_clock(link_clock), .rstn(rstn), .lanes_p(lanes_p),
      .lanes_n(lanes_n), .fwd_p(fwd_p), .fwd_n(fwd_n),
      .word(rx_word), .word_cnt(rx_cnt), .bad_cnt(rx_bad));
   // Clocks: link clock offset so the two never share phase
   initial begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end
   initial begin
      link_clock = 1'b0;
      #7;
      forever #32 link_clock = ~link_clock;
   end
   task automatic check(input lvs_word_t got, input lvs_word_t exp);
      n_tests++;
      if (got !== exp) begin
         error_cnt++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic results;
      $display("errors=%0d checks=%0d", error_cnt, n_tests);
      if (error_cnt == 0 && n_tests > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   // Converter data only on the low eight pins, never zero
   function automatic lvs_word_t rnd();
      return {20'h0, 8'($urandom_range(255, 1))};
   endfunction
   // One strobe period; data moves on the edge that is not captured
   task automatic send(input logic s, input lvs_word_t d, input int half);
      @(posedge clock);
      #1;
      sel = s;
      strobe = ~s;
      din = d;
      repeat (half) @(posedge clock);
      #1 strobe = s;
      exp_q.push_back(d);
      repeat (half) @(posedge clock);
   endtask
   // Idle zero words are skipped; during a burst lost words are passed
   always @(rx_cnt) begin
      if (rx_word !== '0) begin
         got_cnt++;
         while (lossy && exp_q.size() > 1 && exp_q[0] !== rx_word)
            void'(exp_q.pop_front());
         if (exp_q.size() == 0) check(rx_word, '0);
         else check(rx_word, exp_q.pop_front());
      end
   end
   // Overrun is registered on the rising edge, so look mid-cycle
   always @(negedge clock) begin
      if (ovr === 1'b1) ovr_cnt++;
   end
   // Hang guard, well above the roughly 1000 cycles the run needs
   always @(posedge clock) begin
      cycles++;
      if (cycles == 3000) begin
         error_cnt++;
         $display("BAD t=%0t got=%h exp=%h", $time, cycles, 0);
         results();
      end
   end
   initial begin
      rstn = 1'b0;
      strobe = 1'b0;
      sel = 1'b0;
      din = '0;
      lossy = 1'b0;
      error_cnt = 0;
      n_tests = 0;
      cycles = 0;
      ovr_cnt = 0;
      got_cnt = 0;
      void'($urandom(9));
      repeat (20) @(posedge clock);
      // Outputs parked while reset is held
      check(lvs_word_t'({lanes_p, lanes_n, fwd_p, fwd_n, ovr}),
            lvs_word_t'({4'h0, 4'hf, 3'h2}));
      #1 rstn = 1'b1;
      // Falling edge strobe first, then rising edge strobe
      for (int k = 0; k < 24; k++) send(k >= 12, rnd(), 8);
      repeat (60) @(posedge clock);
      check(lvs_word_t'(exp_q.size()), '0);
      check(lvs_word_t'(ovr_cnt), '0);
      // Strobe faster than the link drains: words get refused
      lossy = 1'b1;
      base = got_cnt;
      for (int k = 0; k < 30; k++) send(1'b0, rnd(), 3);
      repeat (300) @(posedge clock);
      check(lvs_word_t'(ovr_cnt != 0), 28'h1);
      // Buffer plus capture stage must have delivered at least nine
      check(lvs_word_t'(got_cnt - base >= 9), 28'h1);
      check(lvs_word_t'(rx_bad), '0);
      results();
   end
endmodule
